// ===== rtl/serial_register_access.sv
`timescale 1ns/10ps
// Contract
// - mode strap sampled at power up: F gives SPI, L gives SMBus, H and R unused
// - SMBus address is 0x2D plus four times strap a index plus strap b index
// - SMBus port works with serial clock up to 400 kHz
// - address byte holds target address in bits 7:1, direction in bit 0
// - nine clocks per byte; receiver pulls data low on ninth to acknowledge
// - target only pulls lines low or releases them; controller drives the clock
// - write: address, register address, one data byte, each acknowledged, data stored
// - read: register address written, repeated start, address with direction 1, data returned
// - SPI target takes clock, active-low select and input data, returns output data
// - each SPI frame per device is exactly 17 bits while select is low
// - with select high input is ignored and output is floated
// - output driver enabled asynchronously as select falls
// - frame order: direction bit, address bits 7..0, data bits 7..0
// - device acts as 17-bit shift register returning the previous frame
// - input sampled on rising clock edges from the first edge after select falls
// - write frame executes on the rising edge of select
// - read is two frames; first carries direction 1, address, eight ignored ones
// - second frame, dummy read of 0xFF, returns address then read data
// - daisy chains hold select low for 17 times N clocks
module serial_register_access
  import serial_access_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // straps
  input wire logic [1:0] i_mode_sel_level,
  input wire logic [1:0] i_target_address_strap_a,
  input wire logic [1:0] i_target_address_strap_b,
  // smbus pins, open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_scl_out,
  output logic o_scl_oe,
  // spi pins
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // register port
  input wire logic [7:0] i_reg_rdata,
  output reg_req_type o_reg_req,
  // status
  output mode_type o_mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; 400 kHz leaves hundreds of core cycles per bit
  pins_type pins_s;

  pin_sync #(
    .W($bits(pins_type)),
    .INIT(PIN_SYNC_INIT)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_async({i_scl, i_sda, i_sck, i_ss_n, i_mosi, i_mode_sel_level, i_target_address_strap_a,
              i_target_address_strap_b}),
    .o_sync(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_done_q, strap_done_d;
  mode_type mode_q, mode_d;
  logic [6:0] target_addr_q, target_addr_d;

  always_comb begin
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    mode_d = mode_q;
    target_addr_d = target_addr_q;
    if (!strap_done_q) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_d = 1'b1;
        // reserved levels leave both ports dead rather than guessing
        unique case (pins_s.mode_lvl)
          LVL_F: mode_d = MODE_SPI;
          LVL_L: mode_d = MODE_SMB;
          default: mode_d = MODE_NONE;
        endcase
        target_addr_d = strap_address(pins_s.strap_a, pins_s.strap_b);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      mode_q <= MODE_NONE;
      target_addr_q <= SMB_ADDR_BASE;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      mode_q <= mode_d;
      target_addr_q <= target_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // smbus target
  smb_state_type state_q, state_d;
  logic scl_prev_q, scl_prev_d;
  logic sda_prev_q, sda_prev_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] byte_q, byte_d;
  logic rw_q, rw_d;
  logic sda_oe_q, sda_oe_d;
  logic [1:0] wait_q, wait_d;
  reg_req_type smb_req_q, smb_req_d;
  logic smb_en, scl_rise, scl_fall, start_det, stop_det;

  assign smb_en = (mode_q == MODE_SMB);
  assign scl_rise = pins_s.scl & ~scl_prev_q;
  assign scl_fall = ~pins_s.scl & scl_prev_q;
  assign start_det = pins_s.scl & scl_prev_q & sda_prev_q & ~pins_s.sda;
  assign stop_det = pins_s.scl & scl_prev_q & ~sda_prev_q & pins_s.sda;

  always_comb begin
    scl_prev_d = pins_s.scl;
    sda_prev_d = pins_s.sda;
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    byte_d = byte_q;
    rw_d = rw_q;
    sda_oe_d = sda_oe_q;
    wait_d = {wait_q[0], 1'b0};
    smb_req_d = smb_req_q;
    smb_req_d.wr = 1'b0;
    smb_req_d.rd = 1'b0;
    if (wait_q[1]) begin
      shift_d = i_reg_rdata;
    end
    if (!smb_en) begin
      state_d = SMB_IDLE;
      sda_oe_d = 1'b0;
    end else if (stop_det) begin
      state_d = SMB_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_det) begin
      state_d = SMB_RX;
      bit_d = 4'h0;
      byte_d = SMB_BYTE_ADDR;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        SMB_IDLE: begin
          sda_oe_d = 1'b0;
        end
        SMB_RX: begin
          if (scl_rise && bit_q != SMB_BYTE_BITS) begin
            shift_d = {shift_q[6:0], pins_s.sda};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == SMB_BYTE_BITS) begin
            state_d = SMB_ACK;
            sda_oe_d = 1'b1;
            unique case (byte_q)
              SMB_BYTE_ADDR: begin
                rw_d = shift_q[0];
                if (shift_q[7:1] != target_addr_q) begin
                  state_d = SMB_IDLE;
                  sda_oe_d = 1'b0;
                end else if (shift_q[0]) begin
                  smb_req_d.rd = 1'b1;
                  wait_d[0] = 1'b1;
                end
              end
              SMB_BYTE_REG: smb_req_d.addr = shift_q;
              SMB_BYTE_DATA: begin
                smb_req_d.wr = 1'b1;
                smb_req_d.wdata = shift_q;
              end
              default: begin
                // only one data byte per write; more are refused
                state_d = SMB_IDLE;
                sda_oe_d = 1'b0;
              end
            endcase
          end
        end
        SMB_ACK: begin
          // also serves as the wait before each read byte goes out
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              state_d = SMB_TX;
              sda_oe_d = ~shift_q[7];
            end else begin
              state_d = SMB_RX;
              sda_oe_d = 1'b0;
              byte_d = (byte_q == SMB_BYTE_EXTRA) ? byte_q : byte_q + 2'h1;
            end
          end
        end
        SMB_TX: begin
          if (scl_fall) begin
            if (bit_q == SMB_TX_LAST) begin
              state_d = SMB_TXACK;
              sda_oe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        SMB_TXACK: begin
          if (scl_rise) begin
            if (pins_s.sda) begin
              state_d = SMB_IDLE;
            end else begin
              // controller wants more: next register follows
              state_d = SMB_ACK;
              smb_req_d.addr = smb_req_q.addr + 8'h01;
              smb_req_d.rd = 1'b1;
              wait_d[0] = 1'b1;
            end
          end
        end
        default: begin
          state_d = SMB_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= SMB_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      byte_q <= SMB_BYTE_ADDR;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wait_q <= 2'h0;
      smb_req_q <= '0;
    end else begin
      state_q <= state_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      sda_oe_q <= sda_oe_d;
      wait_q <= wait_d;
      smb_req_q <= smb_req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // spi target
  reg_req_type spi_req;

  spi_frame_target u_spi (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_enable(mode_q == MODE_SPI),
    .i_ss_n_pin(i_ss_n),
    .i_sck_s(pins_s.sck),
    .i_ss_n_s(pins_s.ss_n),
    .i_mosi_s(pins_s.mosi),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .i_reg_rdata(i_reg_rdata),
    .o_req(spi_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register port and pin outputs
  reg_req_type req_q, req_d;

  always_comb begin
    req_d = (mode_q == MODE_SPI) ? spi_req : smb_req_q;
  end

  // data line is open drain: output value stays low, only the enable moves
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      req_q <= '0;
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
    end else begin
      req_q <= req_d;
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe <= 1'b0;
    end
  end

  assign o_reg_req = req_q;
  assign o_sda_oe = sda_oe_q;
  assign o_mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  logic quiet;
  assign quiet = !start_det && !stop_det;

  a_reserved_quiet: assert property (mode_q == MODE_NONE |-> !o_sda_oe && !o_miso_oe && !o_reg_req.wr)
    else $error("reserved mode is not quiet");
  a_strap_addr: assert property ($rose(strap_done_q) |-> target_addr_q == strap_address($past(pins_s.strap_a),
    $past(pins_s.strap_b))) else $error("target address not from straps");
  a_addr_match: assert property (smb_en && quiet && state_q == SMB_RX && scl_fall && bit_q == SMB_BYTE_BITS &&
    byte_q == SMB_BYTE_ADDR |=> (state_q == SMB_ACK) == ($past(shift_q[7:1]) == target_addr_q))
    else $error("address byte decoded wrongly");
  a_start_rx: assert property (smb_en && start_det && !stop_det |=> state_q == SMB_RX && bit_q == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (smb_en && stop_det |=> state_q == SMB_IDLE && !o_sda_oe)
    else $error("stop did not idle");
  a_ack_drive: assert property (state_q == SMB_ACK && $past(state_q) == SMB_RX |-> o_sda_oe)
    else $error("acknowledge not driven");
  a_low_only: assert property (!o_sda_out && !o_scl_oe && (!o_sda_oe || (state_q inside {SMB_ACK, SMB_TX})))
    else $error("line driven outside ack or data");
  a_write_strobe: assert property (smb_req_q.wr && smb_en |=> o_reg_req.wr && o_reg_req.wdata == $past(smb_req_q.wdata))
    else $error("write not passed to register port");
  a_read_first: assert property (smb_en && quiet && state_q == SMB_ACK && scl_fall && rw_q |=>
    state_q == SMB_TX && o_sda_oe == !$past(shift_q[7])) else $error("read data bit wrong");
  a_nack_release: assert property (smb_en && quiet && state_q == SMB_TXACK && scl_rise && pins_s.sda |=>
    state_q == SMB_IDLE && !o_sda_oe) else $error("nack did not release");

  c_smb_write: cover property (smb_en && o_reg_req.wr);
  c_smb_read_nack: cover property (smb_en && state_q == SMB_TXACK && scl_rise && pins_s.sda);

endmodule : serial_register_access

// ===== rtl/serial_access_pkg.sv
package serial_access_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // four-level strap codes, ordered as the address arithmetic needs them
  localparam logic [1:0] LVL_L = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_H = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // counts and reset values
  localparam logic [6:0] SMB_ADDR_BASE = 7'h2d;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] SMB_BYTE_BITS = 4'h8;
  localparam logic [3:0] SMB_TX_LAST = 4'h7;
  localparam logic [1:0] SMB_BYTE_ADDR = 2'h0;
  localparam logic [1:0] SMB_BYTE_REG = 2'h1;
  localparam logic [1:0] SMB_BYTE_DATA = 2'h2;
  localparam logic [1:0] SMB_BYTE_EXTRA = 2'h3;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h10;
  localparam logic [16:0] SPI_SHIFT_RESET = 17'h00000;
  localparam logic [10:0] PIN_SYNC_INIT = 11'h680;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    MODE_NONE = 3'h1,
    MODE_SMB = 3'h2,
    MODE_SPI = 3'h4
  } mode_type;

  typedef enum logic [4:0] {
    SMB_IDLE = 5'h01,
    SMB_RX = 5'h02,
    SMB_ACK = 5'h04,
    SMB_TX = 5'h08,
    SMB_TXACK = 5'h10
  } smb_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sck;
    logic ss_n;
    logic mosi;
    logic [1:0] mode_lvl;
    logic [1:0] strap_a;
    logic [1:0] strap_b;
  } pins_type;

  function automatic logic [6:0] strap_address(input logic [1:0] a, input logic [1:0] b);
    strap_address = SMB_ADDR_BASE + {3'h0, a, 2'h0} + {5'h0, b};
  endfunction : strap_address

endpackage : serial_access_pkg

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import serial_access_pkg::*;
#(
  parameter int W = 11,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // pins
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // the first stage feeds the second only
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          meta_q <= INIT[g];
          sync_q <= INIT[g];
        end else begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule : pin_sync

// ===== rtl/spi_frame_target.sv
`timescale 1ns/10ps
module spi_frame_target
  import serial_access_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // control
  input wire logic i_enable,
  // link, raw select plus synchronised copies
  input wire logic i_ss_n_pin,
  input wire logic i_sck_s,
  input wire logic i_ss_n_s,
  input wire logic i_mosi_s,
  output logic o_miso,
  output logic o_miso_oe,
  // register port
  input wire logic [7:0] i_reg_rdata,
  output reg_req_type o_req
);

  logic sck_prev_q, sck_prev_d;
  logic ss_prev_q, ss_prev_d;
  logic [16:0] sr_q, sr_d;
  logic [4:0] cnt_q, cnt_d;
  logic full_q, full_d;
  logic [1:0] wait_q, wait_d;
  reg_req_type req_q, req_d;
  logic sck_rise, ss_fall, ss_rise, active, exec;

  assign sck_rise = i_sck_s & ~sck_prev_q;
  assign ss_fall = ~i_ss_n_s & ss_prev_q;
  assign ss_rise = i_ss_n_s & ~ss_prev_q;
  assign active = ~i_ss_n_s & i_enable;
  // a frame counts only when a whole multiple of 17 clocks went by, so a chain still works
  assign exec = ss_rise & i_enable & full_q & (cnt_q == 5'h00);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sck_prev_d = i_sck_s;
    ss_prev_d = i_ss_n_s;
    sr_d = sr_q;
    cnt_d = cnt_q;
    full_d = full_q;
    wait_d = {wait_q[0], 1'b0};
    req_d = req_q;
    req_d.wr = 1'b0;
    req_d.rd = 1'b0;
    if (ss_fall) begin
      cnt_d = 5'h00;
      full_d = 1'b0;
    end
    if (active && sck_rise) begin
      sr_d = {sr_q[15:0], i_mosi_s};
      if (cnt_q == SPI_FRAME_LAST) begin
        cnt_d = 5'h00;
        full_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (exec) begin
      req_d.addr = sr_q[15:8];
      if (sr_q[16]) begin
        // read: data byte of the frame is filler and ignored
        req_d.rd = 1'b1;
        wait_d[0] = 1'b1;
      end else begin
        req_d.wr = 1'b1;
        req_d.wdata = sr_q[7:0];
      end
    end
    // the next frame then returns direction, address and the data read
    if (wait_q[1]) begin
      sr_d[7:0] = i_reg_rdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
      sr_q <= SPI_SHIFT_RESET;
      cnt_q <= 5'h00;
      full_q <= 1'b0;
      wait_q <= 2'h0;
      req_q <= '0;
    end else begin
      sck_prev_q <= sck_prev_d;
      ss_prev_q <= ss_prev_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      wait_q <= wait_d;
      req_q <= req_d;
    end
  end

  assign o_miso = sr_q[16];
  // driver turns on straight from the select pin, no clock in the path
  assign o_miso_oe = ~i_ss_n_pin & i_enable;
  assign o_req = req_q;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_miso_float: assert property (i_ss_n_pin |-> !o_miso_oe) else $error("miso driven while deselected");
  a_async_oe: assert property (!i_ss_n_pin && i_enable |-> o_miso_oe) else $error("miso not enabled");
  a_shift_in: assert property (active && sck_rise |=> sr_q[16:1] == $past(sr_q[15:0]) && sr_q[0] == $past(i_mosi_s))
    else $error("shift register did not shift");
  a_frame_wrap: assert property (active && sck_rise && cnt_q == SPI_FRAME_LAST |=> cnt_q == 5'h00 && full_q)
    else $error("frame count did not wrap at 17");
  a_write_exec: assert property (exec && !sr_q[16] |=> o_req.wr && o_req.addr == $past(sr_q[15:8]))
    else $error("write frame not executed");
  a_read_load: assert property (exec && sr_q[16] |=> ##1 wait_q[1] ##1 sr_q[7:0] == $past(i_reg_rdata))
    else $error("read data not loaded");

  c_spi_write: cover property (exec && !sr_q[16]);
  c_spi_read: cover property (exec && sr_q[16]);

endmodule : spi_frame_target

// ===== dv/serial_controller_model.sv
`timescale 1ns/10ps
module serial_controller_model (
  // design side of the pins
  input wire logic i_sda_out,
  input wire logic i_sda_oe,
  input wire logic i_scl_out,
  input wire logic i_scl_oe,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  // resolved lines
  output logic o_scl,
  output logic o_sda,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi
);
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  logic miso_line;

  ////////////////////////////////////////////////////////////////////////////////
  // pull-ups: a line is low only while some party pulls it
  assign o_scl = ~(scl_pull | (i_scl_oe & ~i_scl_out));
  assign o_sda = ~(sda_pull | (i_sda_oe & ~i_sda_out));
  assign miso_line = i_miso_oe ? i_miso : 1'bz;

  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end

  // deselected data keeps toggling so a stray sample cannot look clean
  always #40 if (o_ss_n) o_mosi = ~o_mosi;

  ////////////////////////////////////////////////////////////////////////////////
  // smbus, 2500 ns per clock
  task automatic smb_start();
    sda_pull = 1'b0;
    #625 scl_pull = 1'b0;
    #625 sda_pull = 1'b1;
    #625 scl_pull = 1'b1;
  endtask : smb_start

  task automatic smb_stop();
    sda_pull = 1'b1;
    #625 scl_pull = 1'b0;
    #625 sda_pull = 1'b0;
    #625;
  endtask : smb_stop

  // eight bits then the acknowledge slot; a one releases the line
  task automatic smb_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic [8:0] word;
    word = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_pull = ~word[i];
      #625 scl_pull = 1'b0;
      #625 word[i] = o_sda;
      #625 scl_pull = 1'b1;
      #625;
    end
    {rx, ack} = word;
  endtask : smb_byte

  ////////////////////////////////////////////////////////////////////////////////
  // spi, 125 ns per clock, clock still outside frames
  task automatic spi_xfer(input int n, input logic [33:0] tx, output logic [33:0] rx, output logic [1:0] oe);
    rx = '0;
    o_ss_n = 1'b0;
    #2 oe[1] = i_miso_oe;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = tx[i];
      #62.5 rx[i] = miso_line;
      o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    #62.5 o_ss_n = 1'b1;
    #200 oe[0] = i_miso_oe;
  endtask : spi_xfer
endmodule : serial_controller_model

// ===== dv/serial_register_access_tb.sv
`timescale 1ns/10ps
module serial_register_access_tb;
  import serial_access_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [1:0] mode_lvl = LVL_F;
  logic [1:0] strap_a = LVL_L;
  logic [1:0] strap_b = LVL_L;
  wire scl, sda, sck, ss_n, mosi;
  logic sda_out, sda_oe, scl_out, scl_oe, miso, miso_oe;
  logic [7:0] reg_rdata;
  reg_req_type reg_req;
  mode_type mode;
  logic [7:0] regs [256];
  int wr_count = 0;
  int fails = 0;
  int samples_checked = 0;

  always #4 i_core_clk = ~i_core_clk;

  // register file behind the port, read combinationally
  assign reg_rdata = regs[reg_req.addr];
  always @(posedge i_core_clk) if (reg_req.wr === 1'b1) begin
    regs[reg_req.addr] <= reg_req.wdata;
    wr_count <= wr_count + 1;
  end

  serial_register_access uut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_mode_sel_level(mode_lvl),
    .i_target_address_strap_a(strap_a), .i_target_address_strap_b(strap_b),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
    .i_reg_rdata(reg_rdata), .o_reg_req(reg_req), .o_mode(mode));

  serial_controller_model ctl (
    .i_sda_out(sda_out), .i_sda_oe(sda_oe), .i_scl_out(scl_out), .i_scl_oe(scl_oe),
    .i_miso(miso), .i_miso_oe(miso_oe), .o_scl(scl), .o_sda(sda), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // straps change under reset; synchronisers hold their reset values until release, then settle before strap capture
  task automatic restart(input logic [1:0] m, input logic [1:0] a, input logic [1:0] b);
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    mode_lvl <= m;
    strap_a <= a;
    strap_b <= b;
    repeat (3) @(posedge i_core_clk);
    i_srst <= 1'b0;
    repeat (10) @(posedge i_core_clk);
  endtask : restart

  ////////////////////////////////////////////////////////////////////////////////
  task automatic spi_scenario();
    logic [33:0] rx;
    logic [1:0] oe;
    int n0;
    check("spi mode", MODE_SPI, mode);
    ctl.spi_xfer(17, {17'h0, 1'b0, 8'h3c, 8'ha5}, rx, oe);
    check("reset shift out", 34'h0, rx);
    check("select drives output", 2'b10, oe);
    check("spi write", 8'ha5, regs[8'h3c]);
    n0 = wr_count;
    ctl.spi_xfer(16, 34'h1234, rx, oe);
    check("short frame dropped", n0, wr_count);
    ctl.spi_xfer(17, {17'h0, 1'b1, 8'h3c, 8'hff}, rx, oe);
    check("previous bits out", 34'h11234, rx);
    ctl.spi_xfer(17, {17'h0, 1'b1, 8'hff, 8'hff}, rx, oe);
    check("read return", {17'h0, 1'b1, 8'h3c, 8'ha5}, rx);
    ctl.spi_xfer(34, {1'b0, 8'h55, 8'h66, 1'b0, 8'h3c, 8'h77}, rx, oe);
    check("chain shift out", {1'b1, 8'hff, 8'h00, 1'b0, 8'h55, 8'h66}, rx);
    check("chain last frame", 8'h77, regs[8'h3c]);
    check("chain first frame", 8'haa, regs[8'h55]);
  endtask : spi_scenario

  // straps R and H give target address 0x34
  task automatic smb_scenario();
    logic [7:0] rx;
    logic ack;
    restart(LVL_L, LVL_R, LVL_H);
    check("smbus mode", MODE_SMB, mode);
    ctl.smb_start();
    ctl.smb_byte(8'h5a, 1'b1, rx, ack);
    check("foreign address", 1'b1, ack);
    ctl.smb_stop();
    ctl.smb_start();
    ctl.smb_byte(8'h68, 1'b1, rx, ack);
    check("address ack", 1'b0, ack);
    ctl.smb_byte(8'h12, 1'b1, rx, ack);
    check("register ack", 1'b0, ack);
    ctl.smb_byte(8'hc3, 1'b1, rx, ack);
    check("data ack", 1'b0, ack);
    ctl.smb_byte(8'h44, 1'b1, rx, ack);
    check("extra byte refused", 1'b1, ack);
    ctl.smb_stop();
    check("smbus write", 8'hc3, regs[8'h12]);
    ctl.smb_start();
    ctl.smb_byte(8'h68, 1'b1, rx, ack);
    ctl.smb_byte(8'h12, 1'b1, rx, ack);
    ctl.smb_start();
    ctl.smb_byte(8'h69, 1'b1, rx, ack);
    check("read address ack", 1'b0, ack);
    ctl.smb_byte(8'hff, 1'b0, rx, ack);
    check("read data", 8'hc3, rx);
    ctl.smb_byte(8'hff, 1'b1, rx, ack);
    check("next read data", 8'hec, rx);
    check("released after nack", 1'b1, sda);
    ctl.smb_stop();
    check("open drain only", 4'b0000, {sda_oe, sda_out, scl_oe, scl_out});
  endtask : smb_scenario

  task automatic reserved_scenario();
    logic [33:0] rx;
    logic [1:0] oe;
    restart(LVL_H, LVL_L, LVL_L);
    check("reserved mode", MODE_NONE, mode);
    ctl.spi_xfer(17, {17'h0, 1'b0, 8'h3c, 8'h11}, rx, oe);
    check("reserved output off", 2'b00, oe);
    check("reserved no write", 8'h77, regs[8'h3c]);
  endtask : reserved_scenario

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #600us;
    fails++;
    $display("CHECK FAILED run length expected finish seen timeout");
    conclude();
  end

  initial begin
    foreach (regs[i]) regs[i] = 8'(~i);
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    spi_scenario();
    smb_scenario();
    reserved_scenario();
    conclude();
  end
endmodule : serial_register_access_tb
